// File: hw/bch_pkg.sv
// constants and types for the bridge configuration header register bank
package bch_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] BCH_IDX_CMD       = 8'h04;
  localparam logic [7:0] BCH_IDX_STATUS    = 8'h06;
  localparam logic [7:0] BCH_IDX_REVISION  = 8'h08;
  localparam logic [7:0] BCH_IDX_SUBCLASS  = 8'h0a;
  localparam logic [7:0] BCH_IDX_BASECLASS = 8'h0b;
  localparam logic [7:0] BCH_IDX_LATENCY   = 8'h0d;
  localparam logic [7:0] BCH_IDX_HEADER    = 8'h0e;
  localparam logic [7:0] BCH_IDX_IRQ_STAT  = 8'h20;
  localparam logic [7:0] BCH_IDX_IRQ_CLR   = 8'h21;
  localparam logic [7:0] BCH_IDX_IRQ_EN    = 8'h22;

  // ----------------------------------------------------------------
  // field positions and fixed values
  // ----------------------------------------------------------------
  localparam int          BCH_CMD_SERR_EN_BIT = 8;
  localparam int          BCH_STS_SSE_BIT     = 14;
  localparam int          BCH_STS_SSE_LANE    = 1;
  localparam logic [15:0] BCH_STS_FIXED       = 16'h00a0;
  localparam logic [15:0] BCH_STS_RESET       = 16'h00a0;
  localparam logic [7:0]  BCH_SUBCLASS_VAL    = 8'h04;
  localparam logic [7:0]  BCH_BASECLASS_VAL   = 8'h06;
  localparam logic [7:0]  BCH_HEADER_VAL      = 8'h01;
  localparam logic [7:0]  BCH_LATENCY_MASK    = 8'hf8;
  localparam logic [7:0]  BCH_LATENCY_RESET   = 8'h00;
  localparam int          BCH_IRQ_SERR_BIT    = 0;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0]  BCH_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  BCH_RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic [1:0]  resp;
    logic [31:0] data;
  } bch_rd_rsp_t;

endpackage : bch_pkg

// File: hw/bch_regs.sv
// bridge configuration header register bank with axi4-lite slave
//
// How it works
// - status bits 15 and 8 are wired to zero and writes do not touch them.
// - status bits 13, 12 and 11 always read zero.
// - status bit 14 sets whenever a system-error message goes upstream for an enabled condition.
// - writing a one to status bit 14 clears it.
// - status bits 10:9 read 00 and cannot be written.
// - status bit 7 is wired to one.
// - status bit 5 is wired to one.
// - after reset the status register reads 00a0 with bit 14 clear.
// - the revision register returns a fixed code and ignores writes.
// - the sub-class register returns 04.
// - the base-class register returns 06.
// - latency bits 7:3 are storage that read back as written, bits 2:0 read zero.
// - the stored latency value steers nothing.
// - the header-type register returns 01 and ignores writes.
// - command bit 8 gates all system-error messages and so the flag.
`timescale 1ns/100ps
module bch_regs
  import bch_pkg::*;
#(
  parameter int         NUM_ERR   = 4,
  parameter logic [7:0] REVISION  = 8'h3c  // arbitrary value
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [NUM_ERR-1:0] err_cond,
  input  wire logic [NUM_ERR-1:0] err_cond_enable,
  output logic                    serr_msg_req,
  output logic                    irq
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_ERR < 1 || NUM_ERR > 16) begin : g_bad_num_err
    $error("NUM_ERR must lie between 1 and 16");
  end

  // ----------------------------------------------------------------
  // bus field positions
  // ----------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int IDX_LSB   = 2;
  localparam int IDX_MSB   = 9;
  localparam int ADDR_MSB  = 31;
  localparam int LOW_LANE  = 0;
  localparam int STS_BITS  = 16;
  // the enable bit sits in the upper byte of the command half-word
  localparam int CMD_LANE  = BCH_CMD_SERR_EN_BIT / BYTE_BITS;

  // ----------------------------------------------------------------
  // constant checks
  // ----------------------------------------------------------------
  if (BCH_STS_FIXED[BCH_STS_SSE_BIT] != 1'b0) begin : g_bad_sts_fixed
    $error("the clearable status bit must not be part of the fixed pattern");
  end
  if (BCH_STS_SSE_BIT / BYTE_BITS != BCH_STS_SSE_LANE) begin : g_bad_sts_lane
    $error("status flag lane does not match its bit position");
  end
  if (BCH_CMD_SERR_EN_BIT >= STS_BITS) begin : g_bad_cmd_bit
    $error("command enable bit lies outside the command half-word");
  end
  if (BCH_IRQ_SERR_BIT >= BYTE_BITS) begin : g_bad_irq_bit
    $error("interrupt bit must sit in the low byte");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        serr_en_ff,   nxt_serr_en;
  logic        sse_ff,       nxt_sse;
  logic [7:0]  latency_ff,   nxt_latency;
  logic        irq_stat_ff,  nxt_irq_stat;
  logic        irq_en_ff,    nxt_irq_en;
  logic        serr_req_ff,  nxt_serr_req;
  logic        bvalid_ff,    nxt_bvalid;
  logic [1:0]  bresp_ff,     nxt_bresp;
  logic        rvalid_ff,    nxt_rvalid;
  bch_rd_rsp_t rsp_ff,       nxt_rsp;

  logic        wr_take;
  logic        rd_take;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        wr_ok;
  logic        msg_fire;
  logic [15:0] status_rd;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [NUM_ERR-1:0] cond_hit;
  logic        sel_cmd;
  logic        sel_status;
  logic        sel_latency;
  logic        sel_irq_clr;
  logic        sel_irq_en;

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  // both write channels taken together, so no address needs holding
  assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign rd_take       = s_axi_arvalid && !rvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign wr_idx        = s_axi_awaddr[IDX_MSB:IDX_LSB];
  assign rd_idx        = s_axi_araddr[IDX_MSB:IDX_LSB];

  always_comb begin
    wr_ok = 1'b1;
    if (s_axi_awaddr[IDX_LSB-1:0] != '0 || s_axi_awaddr[ADDR_MSB:IDX_MSB+1] != '0) begin
      wr_ok = 1'b0;
    end else begin
      unique case (wr_idx)
        BCH_IDX_CMD, BCH_IDX_STATUS, BCH_IDX_REVISION, BCH_IDX_SUBCLASS,
        BCH_IDX_BASECLASS, BCH_IDX_LATENCY, BCH_IDX_HEADER,
        BCH_IDX_IRQ_STAT, BCH_IDX_IRQ_CLR, BCH_IDX_IRQ_EN: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // system-error messaging
  // ----------------------------------------------------------------
  // each condition must be enabled on its own before it can count
  for (genvar g = 0; g < NUM_ERR; g++) begin : g_cond
    assign cond_hit[g] = err_cond[g] && err_cond_enable[g];
  end

  // the global enable gates every condition, so a cleared enable can never set the flag
  assign msg_fire = serr_en_ff && |cond_hit;

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  always_comb begin
    sel_cmd     = 1'b0;
    sel_status  = 1'b0;
    sel_latency = 1'b0;
    sel_irq_clr = 1'b0;
    sel_irq_en  = 1'b0;
    if (wr_take && wr_ok) begin
      unique case (wr_idx)
        BCH_IDX_CMD:     sel_cmd     = 1'b1;
        BCH_IDX_STATUS:  sel_status  = 1'b1;
        BCH_IDX_LATENCY: sel_latency = 1'b1;
        BCH_IDX_IRQ_CLR: sel_irq_clr = 1'b1;
        BCH_IDX_IRQ_EN:  sel_irq_en  = 1'b1;
        // revision, class codes, header type and irq status take no writes
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command group
  // ----------------------------------------------------------------
  always_comb begin
    nxt_serr_en = serr_en_ff;
    if (sel_cmd && s_axi_wstrb[CMD_LANE]) begin
      nxt_serr_en = s_axi_wdata[BCH_CMD_SERR_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // latency storage group
  // ----------------------------------------------------------------
  always_comb begin
    nxt_latency = latency_ff;
    if (sel_latency && s_axi_wstrb[LOW_LANE]) begin
      nxt_latency = s_axi_wdata[BYTE_BITS-1:0] & BCH_LATENCY_MASK;
    end
  end

  // ----------------------------------------------------------------
  // flag group
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sse      = sse_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_en   = irq_en_ff;
    nxt_serr_req = msg_fire;
    // only bit 14 is storage; a zero leaves it alone
    if (sel_status && s_axi_wstrb[BCH_STS_SSE_LANE] && s_axi_wdata[BCH_STS_SSE_BIT]) begin
      nxt_sse = 1'b0;
    end
    if (sel_irq_clr && s_axi_wstrb[LOW_LANE] && s_axi_wdata[BCH_IRQ_SERR_BIT]) begin
      nxt_irq_stat = 1'b0;
    end
    if (sel_irq_en && s_axi_wstrb[LOW_LANE]) begin
      nxt_irq_en = s_axi_wdata[BCH_IRQ_SERR_BIT];
    end
    // set after clear so a same-cycle event survives
    if (msg_fire) begin
      nxt_sse      = 1'b1;
      nxt_irq_stat = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // hardwired bits come only from the fixed pattern, never from storage
  for (genvar b = 0; b < STS_BITS; b++) begin : g_status
    if (b == BCH_STS_SSE_BIT) begin : g_flag
      assign status_rd[b] = sse_ff;
    end else begin : g_fixed
      assign status_rd[b] = BCH_STS_FIXED[b];
    end
  end

  always_comb begin
    rd_word = 32'h0;
    rd_ok   = 1'b1;
    if (s_axi_araddr[IDX_LSB-1:0] != '0 || s_axi_araddr[ADDR_MSB:IDX_MSB+1] != '0) begin
      rd_ok = 1'b0;
    end else begin
      unique case (rd_idx)
        BCH_IDX_CMD:       rd_word[BCH_CMD_SERR_EN_BIT] = serr_en_ff;
        BCH_IDX_STATUS:    rd_word[15:0] = status_rd;
        BCH_IDX_REVISION:  rd_word[7:0]  = REVISION;
        BCH_IDX_SUBCLASS:  rd_word[7:0]  = BCH_SUBCLASS_VAL;
        BCH_IDX_BASECLASS: rd_word[7:0]  = BCH_BASECLASS_VAL;
        BCH_IDX_LATENCY:   rd_word[7:0]  = latency_ff;
        BCH_IDX_HEADER:    rd_word[7:0]  = BCH_HEADER_VAL;
        BCH_IDX_IRQ_STAT:  rd_word[BCH_IRQ_SERR_BIT] = irq_stat_ff;
        BCH_IDX_IRQ_CLR:   rd_word = 32'h0;
        BCH_IDX_IRQ_EN:    rd_word[BCH_IRQ_SERR_BIT] = irq_en_ff;
        default:           rd_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  always_comb begin
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // a new write is only taken once the old answer is gone, so both branches never race
    if (wr_take) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_ok ? BCH_RESP_OKAY : BCH_RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // read response
  // ----------------------------------------------------------------
  // data is captured at the address handshake, so later register changes cannot tear it
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rsp    = rsp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (rd_take) begin
      nxt_rvalid   = 1'b1;
      nxt_rsp.data = rd_word;
      nxt_rsp.resp = rd_ok ? BCH_RESP_OKAY : BCH_RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serr_en_ff <= 1'b0;
    end else begin
      serr_en_ff <= nxt_serr_en;
    end
  end

  // ----------------------------------------------------------------
  // latency storage register
  // ----------------------------------------------------------------
  // kept apart from every other group: only read data looks at it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latency_ff <= BCH_LATENCY_RESET;
    end else begin
      latency_ff <= nxt_latency;
    end
  end

  // ----------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sse_ff      <= BCH_STS_RESET[BCH_STS_SSE_BIT];
      irq_stat_ff <= 1'b0;
      irq_en_ff   <= 1'b0;
      serr_req_ff <= 1'b0;
    end else begin
      sse_ff      <= nxt_sse;
      irq_stat_ff <= nxt_irq_stat;
      irq_en_ff   <= nxt_irq_en;
      serr_req_ff <= nxt_serr_req;
    end
  end

  // ----------------------------------------------------------------
  // response registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= BCH_RESP_OKAY;
    end else begin
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rsp_ff    <= '0;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rsp_ff    <= nxt_rsp;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // latency_ff drives only read data; it has no bus timing role
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rsp_ff.data;
  assign s_axi_rresp  = rsp_ff.resp;
  assign serr_msg_req = serr_req_ff;
  assign irq          = irq_stat_ff && irq_en_ff;

endmodule : bch_regs

// File: verification/bch_regs_monitor.sv
// assertion checker for the bridge configuration header register bank
`timescale 1ns/100ps
module bch_regs_monitor
  import bch_pkg::*;
#(
  parameter int NUM_ERR = 4
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               serr_msg_req,
  input wire logic [31:0]        s_axi_araddr,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [NUM_ERR-1:0] err_cond,
  input wire logic [NUM_ERR-1:0] err_cond_enable
);
  // ----------------------------------------------------------------
  // read address capture, the bus drops araddr once it is taken
  // ----------------------------------------------------------------
  logic [31:0] rd_addr_ff;
  logic [31:0] nxt_rd_addr;
  always_comb nxt_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_ff;
  always_ff @(posedge aclk) rd_addr_ff <= nxt_rd_addr;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_status_fixed_bits: assert property (
    s_axi_rvalid && rd_addr_ff == 32'h18 |-> (s_axi_rdata & 32'hffffbfff) == 32'h000000a0) else $error("status bits");
  a_subclass_value: assert property (s_axi_rvalid && rd_addr_ff == 32'h28 |-> s_axi_rdata == 32'h4)
    else $error("subclass");
  a_baseclass_value: assert property (s_axi_rvalid && rd_addr_ff == 32'h2c |-> s_axi_rdata == 32'h6)
    else $error("base class");
  a_header_value: assert property (s_axi_rvalid && rd_addr_ff == 32'h38 |-> s_axi_rdata == 32'h1)
    else $error("header type");
  a_latency_low_zero: assert property (s_axi_rvalid && rd_addr_ff == 32'h34 |-> s_axi_rdata[2:0] == 3'h0)
    else $error("latency low bits");
  a_serr_has_cause: assert property (serr_msg_req |-> $past(|(err_cond & err_cond_enable)))
    else $error("message without enabled condition");
endmodule : bch_regs_monitor

bind bch_regs bch_regs_monitor #(.NUM_ERR(NUM_ERR)) i_bch_regs_monitor (.*);

// File: verification/bch_regs_tb_top.sv
// self-checking bench for the bridge configuration header register bank
`timescale 1ns/100ps
module bch_regs_tb_top
  import bch_pkg::*;
;
  localparam logic [7:0] REV = 8'h5a;  // arbitrary value
  localparam logic [1:0] OK  = BCH_RESP_OKAY;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0, err_cond = 0, err_cond_enable = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serr_msg_req, irq;
  int          err_count = 0, n_tests = 0;
  logic [7:0]  ix [5] = '{BCH_IDX_REVISION, BCH_IDX_SUBCLASS, BCH_IDX_BASECLASS, BCH_IDX_HEADER, BCH_IDX_STATUS};
  logic [31:0] ex [5] = '{{24'h0, REV}, 32'h4, 32'h6, 32'h1, 32'ha0};
  always #5 aclk = ~aclk;
  bch_regs #(.NUM_ERR(4), .REVISION(REV)) i_bch_regs (.*);
  task automatic stop_test;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // ends at a falling edge so the answer is read while it is settled
  task automatic wt(ref logic s);
    int i;
    i = 0;
    do begin
      @(negedge aclk);
      i++;
    end while (s !== 1'b1 && i < 50);
    if (i >= 50) begin
      err_count++;
      $display("MISMATCH %0t no answer", $time);
      stop_test();
    end
  endtask : wt
  task automatic wr(input logic [7:0] ix, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er,
                    input bit coll = 1'b0);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, ix, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    if (coll) err_cond <= 4'h1;
    wt(s_axi_awready);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    err_cond <= 4'h0;
    wt(s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ix, input logic [31:0] exp, input logic [1:0] er = OK);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, ix, 2'h0};
    s_axi_arvalid <= 1'b1;
    wt(s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    wt(s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    // one edge with rvalid up and rready low, so the hold check sees a stall
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  // one-cycle condition pulse, message expected one cycle later
  task automatic ev(input logic [3:0] c, input logic [3:0] e, input logic exp);
    @(posedge aclk);
    err_cond <= c;
    err_cond_enable <= e;
    @(posedge aclk);
    err_cond <= 4'h0;
    @(negedge aclk);
    chk({31'h0, serr_msg_req}, {31'h0, exp});
  endtask : ev
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(BCH_IDX_STATUS, 32'ha0);
    rd(BCH_IDX_LATENCY, 32'h0);
    for (int k = 0; k < 5; k++) begin
      wr(ix[k], 32'hffffffff, 4'hf, OK);
      rd(ix[k], ex[k]);
    end
    wr(BCH_IDX_LATENCY, 32'hff, 4'h1, OK);
    rd(BCH_IDX_LATENCY, 32'hf8);
    wr(BCH_IDX_LATENCY, 32'h57, 4'h1, OK);
    rd(BCH_IDX_LATENCY, 32'h50);
    wr(8'hff, 32'h1, 4'hf, BCH_RESP_SLVERR);
    rd(8'hff, 32'h0, BCH_RESP_SLVERR);
    wr(BCH_IDX_IRQ_EN, 32'h1, 4'h1, OK);
    ev(4'hf, 4'hf, 1'b0);
    rd(BCH_IDX_STATUS, 32'ha0);
    wr(BCH_IDX_CMD, 32'h100, 4'h2, OK);
    ev(4'h2, 4'h1, 1'b0);
    ev(4'h1, 4'h1, 1'b1);
    rd(BCH_IDX_STATUS, 32'h40a0);
    rd(BCH_IDX_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(BCH_IDX_STATUS, 32'h0, 4'hf, OK);
    rd(BCH_IDX_STATUS, 32'h40a0);
    wr(BCH_IDX_STATUS, 32'h4000, 4'h2, OK);
    rd(BCH_IDX_STATUS, 32'ha0);
    wr(BCH_IDX_IRQ_EN, 32'h0, 4'h1, OK);
    chk({31'h0, irq}, 32'h0);
    wr(BCH_IDX_IRQ_CLR, 32'h1, 4'h1, OK);
    rd(BCH_IDX_IRQ_STAT, 32'h0);
    wr(BCH_IDX_STATUS, 32'h4000, 4'h2, OK, 1'b1);
    rd(BCH_IDX_STATUS, 32'h40a0);
    stop_test();
  end
endmodule : bch_regs_tb_top
